// ### hdl/mmsc_pkg.sv
// Constants and types shared by the multi-motor staging controller
package mmsc_pkg;
   // Clock period of the control clock in nanoseconds
   localparam int unsigned CLK_PERIOD_NS = 8;
   // Base timing unit of every delay setting: 0.1 s, in nanoseconds
   localparam int unsigned TENTH_SEC_NS  = 100000000;
   // Clock cycles in one tenth of a second (exact at 125 MHz)
   localparam int unsigned TENTH_CYCLES  = TENTH_SEC_NS / CLK_PERIOD_NS;
   // Tenths per minute and minutes per hour for the elapsed-time display
   localparam logic [9:0]  TENTHS_PER_MIN = 10'h258;
   localparam logic [5:0]  MIN_PER_HOUR   = 6'h3c;
   // Relay count, field widths
   localparam int unsigned NUM_AUX  = 4;
   localparam int unsigned FREQ_W   = 16;
   localparam int unsigned FB_W     = 12;
   // Rotation modes
   localparam logic [1:0]  ROT_NONE = 2'h0;
   localparam logic [1:0]  ROT_AUX  = 2'h1;
   localparam logic [1:0]  ROT_ALL  = 2'h2;
   // Frequency source codes that allow regulator bypass
   localparam logic [2:0]  SRC_VOLTAGE = 3'h2;
   localparam logic [2:0]  SRC_CURRENT = 3'h3;
   localparam logic [2:0]  SRC_PULSE   = 3'h4;
   // Reset values
   localparam logic [2:0]  COUNT_RESET = 3'h0;
   localparam logic [1:0]  ORDER_RESET = 2'h0;
   // Staging states, one-hot
   typedef enum logic [3:0] {
      MMSC_IDLE  = 4'h1,
      MMSC_RUN   = 4'h2,
      MMSC_TRIP  = 4'h4,
      MMSC_SLEEP = 4'h8
   } mmsc_state_t;
endpackage

// ### hdl/mmsc_top.sv
// Multi-motor staging controller: relay staging, sleep, bypass and displays
`timescale 1ns/1ps
`default_nettype none
module mmsc_top
   import mmsc_pkg::*;
#(
   parameter int unsigned TENTH_CYC = TENTH_CYCLES // Cycles per 0.1 s
)(
   input  wire logic              CLK,
   input  wire logic              RST,
   input  wire logic              CE,
   input  wire logic              RUN_CMD,
   input  wire logic              REGULATOR_MODE_SELECT,
   input  wire logic              EXPANSION_FITTED,
   input  wire logic [2:0]        AUX_COUNT,
   input  wire logic [1:0]        FIRST_AUX,
   input  wire logic [1:0]        ROTATION_MODE,
   input  wire logic              ROTATION_REQUEST,
   input  wire logic [3:0]        INTERLOCK_INPUT,
   input  wire logic [15:0]       REGULATOR_OUTPUT,
   input  wire logic [15:0]       OUTPUT_FREQ,
   input  wire logic [11:0]       REFERENCE,
   input  wire logic [11:0]       FEEDBACK,
   input  wire logic [63:0]       AUX_ON_FREQUENCY,
   input  wire logic [63:0]       AUX_OFF_FREQUENCY,
   input  wire logic [11:0]       PRESSURE_DIFFERENCE_THRESHOLD,
   input  wire logic [15:0]       AUX_ON_DELAY,
   input  wire logic [15:0]       AUX_OFF_DELAY,
   input  wire logic [15:0]       STAGING_RAMP_UP_TIME,
   input  wire logic [15:0]       STAGING_RAMP_DOWN_TIME,
   input  wire logic [15:0]       SLEEP_FREQUENCY,
   input  wire logic [15:0]       SLEEP_DELAY,
   input  wire logic [11:0]       WAKE_LEVEL,
   input  wire logic              REGULATOR_BYPASS,
   input  wire logic [2:0]        FREQUENCY_SOURCE_SELECT,
   input  wire logic [15:0]       START_FREQ,
   input  wire logic [15:0]       MAX_FREQ,
   output logic [3:0]             AUX_RELAY,
   output logic [2:0]             RUNNING_AUX_COUNT,
   output logic [7:0]             ROTATION_ELAPSED_HOURS,
   output logic [5:0]             ROTATION_ELAPSED_MINUTES,
   output logic [15:0]            MAIN_FREQ_CMD,
   output logic                   MAIN_RUN,
   output logic                   SLEEPING,
   output logic                   REGULATOR_ENABLE,
   output logic                   VF_MODE_FORCED
);
   // Registers
   mmsc_state_t   state_r, state_nxt;   // Staging state
   logic [31:0]   tick_cnt_r;           // Divider for the 0.1 s tick
   logic [2:0]    stage_r;              // Relays requested in staging order
   logic [15:0]   on_tmr_r;             // Start-delay timer, tenths
   logic [15:0]   off_tmr_r;            // Stop-delay timer, tenths
   logic [15:0]   sleep_tmr_r;          // Sleep-delay timer, tenths
   logic [1:0]    rot_ofs_r;            // Rotation offset of the order
   logic [3:0]    relay_r;              // Registered relay drive
   logic [2:0]    count_r;              // Running relay count
   logic [3:0]    intlk_r;              // Last interlock sample
   logic [9:0]    tenth_r;              // Tenths inside current minute
   logic [5:0]    min_r;                // Elapsed minutes
   logic [7:0]    hour_r;               // Elapsed hours
   logic [15:0]   freq_r;               // Ramped main frequency command
   logic [39:0]   ramp_acc_r;           // Ramp rate accumulator
   logic          ramping_r;            // Ramp window after a stage change

   // Tenth-second tick, frozen with the clock enable
   wire tick = (tick_cnt_r == TENTH_CYC - 1);

   // Bypass is honoured only for analog or pulse frequency sources
   wire src_ok = (FREQUENCY_SOURCE_SELECT == SRC_VOLTAGE) |
                 (FREQUENCY_SOURCE_SELECT == SRC_CURRENT) |
                 (FREQUENCY_SOURCE_SELECT == SRC_PULSE);
   wire bypass = REGULATOR_BYPASS & src_ok;
   wire staging_en = REGULATOR_MODE_SELECT & RUN_CMD;

   // Relay budget: base strip has one relay, expansion unlocks all four
   wire [2:0] hw_max  = EXPANSION_FITTED ? 3'h4 : 3'h1;
   wire [2:0] cfg_max = (AUX_COUNT > hw_max) ? hw_max : AUX_COUNT;
   // Healthy relays, limited to the ones present on the fitted relay strip
   logic [3:0] avail;
   logic [2:0] avail_cnt;
   logic [2:0] rank [NUM_AUX];
   logic [1:0] start_idx;
   assign start_idx = FIRST_AUX + rot_ofs_r;

   // Per relay: present on the fitted strip, healthy and its rank in the staging order
   genvar gi;
   generate
      for (gi = 0; gi < NUM_AUX; gi++) begin : g_relay
         wire [1:0] pos = 2'(gi) - start_idx;
         assign avail[gi] = INTERLOCK_INPUT[gi] & (3'(gi) < hw_max);
         // Healthy relays placed earlier in the order
         always_comb begin
            rank[gi] = 3'h0;
            for (int j = 0; j < NUM_AUX; j++) begin
               if (avail[j] && (2'(j - int'(start_idx)) < pos)) begin
                  rank[gi] = rank[gi] + 3'h1;
               end
            end
         end
      end
   endgenerate
   assign avail_cnt = 3'(avail[0]) + 3'(avail[1]) + 3'(avail[2]) + 3'(avail[3]);
   wire [2:0] stage_max = (avail_cnt < cfg_max) ? avail_cnt : cfg_max;

   // Relay pattern: the first stage_r healthy relays in order
   logic [3:0] relay_want;
   always_comb begin
      for (int i = 0; i < NUM_AUX; i++) begin
         relay_want[i] = avail[i] & (rank[i] < stage_r);
      end
   end
   // Relays drop on the very edge the state leaves run, so a trip never keeps one closed
   wire [3:0] relay_nxt = (state_r == MMSC_RUN && state_nxt == MMSC_RUN) ? relay_want : 4'h0;
   wire [2:0] count_nxt = 3'(relay_nxt[0]) + 3'(relay_nxt[1]) +
                          3'(relay_nxt[2]) + 3'(relay_nxt[3]);

   // Thresholds of the next relay to start and the last one to stop
   wire [1:0]  on_sel   = stage_r[1:0];
   wire [1:0]  off_sel  = 2'(stage_r - 3'h1);
   wire [15:0] on_freq  = AUX_ON_FREQUENCY[16*on_sel +: 16];
   wire [15:0] off_freq = AUX_OFF_FREQUENCY[16*off_sel +: 16];
   wire signed [12:0] pr_diff = $signed({1'b0, REFERENCE}) - $signed({1'b0, FEEDBACK});
   wire signed [12:0] pr_thr  = $signed({1'b0, PRESSURE_DIFFERENCE_THRESHOLD});

   // Bypass level control: feedback split into attached count plus one regions
   wire [14:0] scaled  = 15'(FEEDBACK) * 15'(cfg_max + 3'h1);
   wire [2:0]  region  = scaled[14:12];
   wire [11:0] frac    = scaled[11:0];
   wire [15:0] span    = MAX_FREQ - START_FREQ;
   wire [27:0] span_fr = 28'(span) * 28'(frac);
   wire [15:0] bp_freq = START_FREQ + span_fr[27:12];
   wire [2:0]  bp_stage = (region > stage_max) ? stage_max : region;

   // Staging conditions under regulator control
   wire up_cond = (stage_r < stage_max) & (OUTPUT_FREQ > on_freq) &
                  (pr_diff > pr_thr);
   wire dn_cond = (stage_r != 3'h0) & (OUTPUT_FREQ < off_freq) &
                  (pr_diff < pr_thr);
   wire up_go = up_cond & (on_tmr_r >= AUX_ON_DELAY);
   wire dn_go = dn_cond & (off_tmr_r >= AUX_OFF_DELAY);

   // Interlock falling edge on any requested relay stops everything
   wire intlk_fall = |(intlk_r & ~INTERLOCK_INPUT);
   // Sleep needs a non-zero delay; zero disables it
   wire sleep_go = (SLEEP_DELAY != 16'h0) & (OUTPUT_FREQ < SLEEP_FREQUENCY) &
                   (sleep_tmr_r >= SLEEP_DELAY);
   wire wake_go  = FEEDBACK < WAKE_LEVEL;

   // Next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         MMSC_IDLE: begin
            if (staging_en) state_nxt = MMSC_RUN;
         end
         MMSC_RUN: begin
            if (!staging_en) state_nxt = MMSC_IDLE;
            else if (intlk_fall) state_nxt = MMSC_TRIP;
            else if (sleep_go) state_nxt = MMSC_SLEEP;
         end
         MMSC_TRIP: begin
            // One cycle with every motor off, then restart with healthy ones
            state_nxt = staging_en ? MMSC_RUN : MMSC_IDLE;
         end
         MMSC_SLEEP: begin
            if (!staging_en) state_nxt = MMSC_IDLE;
            else if (wake_go) state_nxt = MMSC_RUN;
         end
         default: state_nxt = MMSC_IDLE;
      endcase
   end

   // Next stage count
   logic [2:0] stage_nxt;
   always_comb begin
      stage_nxt = stage_r;
      if (state_r != MMSC_RUN || state_nxt != MMSC_RUN) begin
         stage_nxt = 3'h0;
      end else if (bypass) begin
         stage_nxt = bp_stage;
      end else if (up_go) begin
         stage_nxt = stage_r + 3'h1;
      end else if (dn_go) begin
         stage_nxt = stage_r - 3'h1;
      end else if (stage_r > stage_max) begin
         stage_nxt = stage_max;
      end
   end

   // Frequency target and ramp step
   wire [15:0] target    = (state_r != MMSC_RUN) ? 16'h0 :
                           bypass ? bp_freq : REGULATOR_OUTPUT;
   wire        going_up  = target > freq_r;
   wire [15:0] ramp_time = going_up ? STAGING_RAMP_UP_TIME : STAGING_RAMP_DOWN_TIME;
   wire [39:0] ramp_lim  = 40'(ramp_time) * 40'(TENTH_CYC);
   wire        ramp_step = ramp_acc_r >= ramp_lim;

   // Tick divider
   always_ff @(posedge CLK) begin
      if (RST) tick_cnt_r <= 32'h0;
      else if (CE) tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
   end

   // State, stage, relays and count
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_r <= MMSC_IDLE;
         stage_r <= COUNT_RESET;
         relay_r <= 4'h0;
         count_r <= COUNT_RESET;
         intlk_r <= 4'h0;
      end else if (CE) begin
         state_r <= state_nxt;
         stage_r <= stage_nxt;
         relay_r <= relay_nxt;
         count_r <= count_nxt;
         intlk_r <= INTERLOCK_INPUT & relay_want;
      end
   end

   // Delay timers count tenths while their condition holds
   always_ff @(posedge CLK) begin
      if (RST) begin
         on_tmr_r    <= 16'h0;
         off_tmr_r   <= 16'h0;
         sleep_tmr_r <= 16'h0;
      end else if (CE) begin
         if (!up_cond || up_go || state_r != MMSC_RUN) on_tmr_r <= 16'h0;
         else if (tick && on_tmr_r != 16'hffff) on_tmr_r <= on_tmr_r + 16'h1;
         if (!dn_cond || dn_go || state_r != MMSC_RUN) off_tmr_r <= 16'h0;
         else if (tick && off_tmr_r != 16'hffff) off_tmr_r <= off_tmr_r + 16'h1;
         if (OUTPUT_FREQ >= SLEEP_FREQUENCY || state_r != MMSC_RUN) sleep_tmr_r <= 16'h0;
         else if (tick && sleep_tmr_r != 16'hffff) sleep_tmr_r <= sleep_tmr_r + 16'h1;
      end
   end

   // Rotation offset and elapsed-time display
   wire rotate = ROTATION_REQUEST & (ROTATION_MODE == ROT_AUX || ROTATION_MODE == ROT_ALL);
   always_ff @(posedge CLK) begin
      if (RST) begin
         rot_ofs_r <= ORDER_RESET;
         tenth_r   <= 10'h0;
         min_r     <= 6'h0;
         hour_r    <= 8'h0;
      end else if (CE) begin
         if (rotate) begin
            rot_ofs_r <= rot_ofs_r + 2'h1;
            tenth_r   <= 10'h0;
            min_r     <= 6'h0;
            hour_r    <= 8'h0;
         end else if (ROTATION_MODE == ROT_NONE) begin
            rot_ofs_r <= ORDER_RESET;
         end
         if (!rotate && tick && state_r == MMSC_RUN) begin
            if (tenth_r == TENTHS_PER_MIN - 10'h1) begin
               tenth_r <= 10'h0;
               if (min_r == MIN_PER_HOUR - 6'h1) begin
                  min_r  <= 6'h0;
                  hour_r <= hour_r + 8'h1;
               end else begin
                  min_r <= min_r + 6'h1;
               end
            end else begin
               tenth_r <= tenth_r + 10'h1;
            end
         end
      end
   end

   // Main motor ramp: one 0.01 Hz step each time the accumulator fills
   always_ff @(posedge CLK) begin
      if (RST) begin
         freq_r     <= 16'h0;
         ramp_acc_r <= 40'h0;
         ramping_r  <= 1'b0;
      end else if (CE) begin
         if (count_nxt != count_r) begin
            ramping_r  <= 1'b1;
            ramp_acc_r <= 40'h0;
         end else if (!ramping_r || freq_r == target || ramp_time == 16'h0) begin
            // Outside a ramp window the command follows the target
            ramping_r  <= 1'b0;
            freq_r     <= target;
            ramp_acc_r <= 40'h0;
         end else if (ramp_step) begin
            freq_r     <= going_up ? freq_r + 16'h1 : freq_r - 16'h1;
            ramp_acc_r <= 40'h0;
         end else begin
            ramp_acc_r <= ramp_acc_r + 40'(MAX_FREQ);
         end
      end
   end

   // Outputs
   assign AUX_RELAY                = relay_r;
   assign RUNNING_AUX_COUNT        = count_r;
   assign ROTATION_ELAPSED_HOURS   = hour_r;
   assign ROTATION_ELAPSED_MINUTES = min_r;
   assign MAIN_FREQ_CMD            = freq_r;
   assign MAIN_RUN                 = (state_r == MMSC_RUN);
   assign SLEEPING                 = (state_r == MMSC_SLEEP);
   assign REGULATOR_ENABLE         = REGULATOR_MODE_SELECT & ~bypass;
   assign VF_MODE_FORCED           = bypass;
endmodule
`default_nettype wire

// ### verif/mmsc_assertions.sv
// Port-level assertions for the staging controller, bound to its top
`timescale 1ns/1ps
`default_nettype none
module mmsc_assertions
   import mmsc_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic        RUN_CMD,
   input wire logic        REGULATOR_MODE_SELECT,
   input wire logic        EXPANSION_FITTED,
   input wire logic [2:0]  AUX_COUNT,
   input wire logic [1:0]  ROTATION_MODE,
   input wire logic        ROTATION_REQUEST,
   input wire logic [3:0]  INTERLOCK_INPUT,
   input wire logic [15:0] OUTPUT_FREQ,
   input wire logic [11:0] FEEDBACK,
   input wire logic [15:0] SLEEP_FREQUENCY,
   input wire logic [15:0] SLEEP_DELAY,
   input wire logic [11:0] WAKE_LEVEL,
   input wire logic        REGULATOR_BYPASS,
   input wire logic [2:0]  FREQUENCY_SOURCE_SELECT,
   input wire logic [3:0]  AUX_RELAY,
   input wire logic [2:0]  RUNNING_AUX_COUNT,
   input wire logic [7:0]  ROTATION_ELAPSED_HOURS,
   input wire logic [5:0]  ROTATION_ELAPSED_MINUTES,
   input wire logic        MAIN_RUN,
   input wire logic        SLEEPING,
   input wire logic        REGULATOR_ENABLE,
   input wire logic        VF_MODE_FORCED
);
   // Bypass is legal only from the voltage, current or pulse source
   wire logic byp_ok = REGULATOR_BYPASS &&
      (FREQUENCY_SOURCE_SELECT inside {SRC_VOLTAGE, SRC_CURRENT, SRC_PULSE});
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   a_count_match: assert property (RUNNING_AUX_COUNT == 3'($countones(AUX_RELAY)))
      else $error("running count differs from relay outputs");
   a_reset_clears: assert property ($past(RST) |-> AUX_RELAY == 4'h0 && !MAIN_RUN &&
      RUNNING_AUX_COUNT == 3'h0 && ROTATION_ELAPSED_MINUTES == 6'h0)
      else $error("outputs not cleared by reset");
   a_stage_gated: assert property ((!(RUN_CMD && REGULATOR_MODE_SELECT) && CE) [*3]
      |-> AUX_RELAY == 4'h0) else $error("relay on outside regulator run");
   a_trip_all_off: assert property (((AUX_RELAY & ~INTERLOCK_INPUT) != 4'h0 && CE)
      |=> AUX_RELAY == 4'h0 && !MAIN_RUN) else $error("interlock did not stop all");
   a_base_single: assert property ((!EXPANSION_FITTED && CE) [*2]
      |-> AUX_RELAY[3:1] == 3'h0) else $error("expansion relay used without option");
   a_count_cap: assert property (RUNNING_AUX_COUNT <= AUX_COUNT)
      else $error("more relays than attached motors");
   a_step_one: assert property (!REGULATOR_BYPASS |->
      RUNNING_AUX_COUNT <= $past(RUNNING_AUX_COUNT) + 3'h1) else $error("stage jumped");
   a_bypass_vf: assert property (VF_MODE_FORCED == byp_ok && !(byp_ok && REGULATOR_ENABLE))
      else $error("bypass mode flags wrong");
   a_sleep_entry: assert property ($rose(SLEEPING) |-> SLEEP_DELAY != 16'h0 &&
      $past(OUTPUT_FREQ) < $past(SLEEP_FREQUENCY)) else $error("sleep without low frequency");
   a_wake_up: assert property ((SLEEPING && FEEDBACK < WAKE_LEVEL && CE) |=> !SLEEPING)
      else $error("no wake below wake level");
   a_time_clear: assert property ((ROTATION_REQUEST && ROTATION_MODE != ROT_NONE && CE)
      |=> ROTATION_ELAPSED_MINUTES == 6'h0 && ROTATION_ELAPSED_HOURS == 8'h0)
      else $error("elapsed time not cleared");
   a_minute_wrap: assert property (ROTATION_ELAPSED_MINUTES < MIN_PER_HOUR)
      else $error("minutes out of range");
endmodule
bind mmsc_top mmsc_assertions u_chk (.CLK, .RST, .CE, .RUN_CMD, .REGULATOR_MODE_SELECT,
   .EXPANSION_FITTED, .AUX_COUNT, .ROTATION_MODE, .ROTATION_REQUEST, .INTERLOCK_INPUT,
   .OUTPUT_FREQ, .FEEDBACK, .SLEEP_FREQUENCY, .SLEEP_DELAY, .WAKE_LEVEL, .REGULATOR_BYPASS,
   .FREQUENCY_SOURCE_SELECT, .AUX_RELAY, .RUNNING_AUX_COUNT, .ROTATION_ELAPSED_HOURS,
   .ROTATION_ELAPSED_MINUTES, .MAIN_RUN, .SLEEPING, .REGULATOR_ENABLE, .VF_MODE_FORCED);
`default_nettype wire

// ### verif/mmsc_partner_model.sv
// Contactor relays, interlock contacts and pressure sensor on the far side
`timescale 1ns/1ps
`default_nettype none
module mmsc_partner_model (
   input  wire logic        clk,
   input  wire logic [3:0]  relay,
   input  wire logic [3:0]  fault,
   input  wire logic [11:0] level,
   output logic [3:0]       interlock,
   output logic [11:0]      feedback
);
   // A faulty motor opens its contact one clock later, like a real auxiliary contact
   always_ff @(posedge clk) begin
      interlock <= ~fault;
   end
   // Each running pump lifts the sensed pressure a little, so feedback copies level only while no pump runs
   assign feedback = level + 12'($countones(relay));
endmodule
`default_nettype wire

// ### verif/mmsc_tb_top.sv
// Self-checking bench for the multi-motor staging controller
`timescale 1ns/1ps
`default_nettype none
module mmsc_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce, run, regm, expn, rreq, byp, mrun, slp, regen, vf;
   logic [1:0]  first, rmode;
   logic [2:0]  acnt, src, cnt;
   logic [3:0]  ilk, fault, relay;
   logic [5:0]  mins;
   logic [7:0]  hrs;
   logic [11:0] refv, fb, level, thr, wake;
   logic [15:0] ofreq, sfreq, sdel, ond, offd, regout, rup, rdn, frq;
   logic [63:0] onf, offf;
   int          fail_count = 0;
   int          checks_done = 0;
   always #4 clk = ~clk;
   // Tenth-second tick shortened to 10 cycles so delays take tens of cycles
   mmsc_top #(.TENTH_CYC(10)) u_dut (.CLK(clk), .RST(rst), .CE(ce), .RUN_CMD(run),
      .REGULATOR_MODE_SELECT(regm), .EXPANSION_FITTED(expn), .AUX_COUNT(acnt),
      .FIRST_AUX(first), .ROTATION_MODE(rmode), .ROTATION_REQUEST(rreq),
      .INTERLOCK_INPUT(ilk), .REGULATOR_OUTPUT(regout), .OUTPUT_FREQ(ofreq),
      .REFERENCE(refv), .FEEDBACK(fb), .AUX_ON_FREQUENCY(onf), .AUX_OFF_FREQUENCY(offf),
      .PRESSURE_DIFFERENCE_THRESHOLD(thr), .AUX_ON_DELAY(ond), .AUX_OFF_DELAY(offd),
      .STAGING_RAMP_UP_TIME(rup), .STAGING_RAMP_DOWN_TIME(rdn),
      .SLEEP_FREQUENCY(sfreq), .SLEEP_DELAY(sdel), .WAKE_LEVEL(wake),
      .REGULATOR_BYPASS(byp), .FREQUENCY_SOURCE_SELECT(src), .START_FREQ(16'h01f4),
      .MAX_FREQ(16'h1770), .AUX_RELAY(relay), .RUNNING_AUX_COUNT(cnt),
      .ROTATION_ELAPSED_HOURS(hrs), .ROTATION_ELAPSED_MINUTES(mins), .MAIN_FREQ_CMD(frq),
      .MAIN_RUN(mrun), .SLEEPING(slp), .REGULATOR_ENABLE(regen), .VF_MODE_FORCED(vf));
   mmsc_partner_model u_far (.clk(clk), .relay(relay),
      .fault(fault), .level(level), .interlock(ilk), .feedback(fb));
   // Inputs always move 1 ns after the edge, never on it
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_cnt(input logic [2:0] e);
      for (int i = 0; i < 400 && cnt !== e; i++) cyc(1);
      chk("running count", e, cnt);
   endtask
   task automatic stop;
      run = 1'b0;
      cyc(4);
   endtask
   // Demand up: high frequency and reference well above feedback; down: the reverse
   task automatic drive(input logic up);
      ofreq = up ? 16'(5000 + $urandom % 3000) : 16'h03e8;
      refv = up ? 12'h800 : 12'h400;
      level = up ? 12'h400 : 12'h800;
   endtask
   // Relays expected for a stage: ranks from the first motor, wrapping, healthy only
   function automatic logic [3:0] exp_rel(input logic [1:0] f, input int n, input logic [3:0] h);
      logic [3:0] r;
      int k;
      r = 4'h0;
      k = 0;
      for (int i = 0; i < 4; i++) begin
         if (h[(f + i) % 4] && k < n) begin
            r[(f + i) % 4] = 1'b1;
            k++;
         end
      end
      return r;
   endfunction
   // Bypass command: feedback cut into n regions, each mapped start to max linearly
   function automatic logic [15:0] bp_exp(input logic [11:0] f, input int n);
      int p;
      p = (int'(f) * n) % 4096;
      return 16'h01f4 + 16'((5500 * p) / 4096);
   endfunction
   task automatic summarize;
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      int n;
      void'($urandom(32'haa7f5fb0));
      {ce, run, regm, expn, rreq, byp} = 6'h2c;
      {acnt, src, first, rmode, fault} = {3'h4, 3'h0, 2'h0, 2'h0, 4'h0};
      {ofreq, sfreq, sdel, ond, offd} = {16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0002};
      {regout, rup, rdn} = {16'h1388, 16'h0000, 16'h0000};
      {refv, level, thr, wake} = {12'h800, 12'h400, 12'h064, 12'h000};
      onf = {4{16'h1387}};
      offf = {16'h05dc, 16'h05dc, 16'h07d0, 16'h07d0};
      cyc(8);
      rst = 1'b0;
      chk("count after reset", 8'h00, cnt);
      chk("minutes after reset", 8'h00, mins);
      // Random first motor and attached count; stage up, then back down
      repeat (3) begin
         first = 2'($urandom % 4);
         acnt = 3'(1 + $urandom % 4);
         n = acnt;
         drive(1'b1);
         run = 1'b1;
         for (int k = 1; k <= n; k++) begin
            wait_cnt(3'(k));
            chk("relays up", exp_rel(first, k, 4'hf), relay);
            cyc(k == n ? 60 : 10);
            chk("count held", 8'(k), cnt);
         end
         drive(1'b0);
         for (int k = n - 1; k >= 0; k--) begin
            wait_cnt(3'(k));
            chk("relays down", exp_rel(first, k, 4'hf), relay);
         end
         stop();
      end
      // Small pressure difference, then regulator mode off: no staging either way
      {first, acnt} = {2'h0, 3'h4};
      drive(1'b1);
      refv = 12'h400;
      run = 1'b1;
      cyc(100);
      chk("count no pressure", 8'h00, cnt);
      {refv, regm} = {12'h800, 1'b0};
      cyc(100);
      chk("count no regulator", 8'h00, cnt);
      regm = 1'b1;
      wait_cnt(3'h4);
      fault = 4'h2;
      cyc(3);
      chk("relays on trip", 8'h00, relay);
      wait_cnt(3'h3);
      chk("relays healthy", exp_rel(2'h0, 3, 4'hd), relay);
      fault = 4'h0;
      stop();
      // Base strip only, then a frozen clock enable holds state
      expn = 1'b0;
      run = 1'b1;
      cyc(300);
      chk("relays base", exp_rel(2'h0, 1, 4'hf), relay);
      {ce, run} = 2'h0;
      cyc(20);
      chk("count frozen", 8'h01, cnt);
      {ce, expn} = 2'h3;
      stop();
      // Elapsed time over two minutes, then rotation requests in every mode
      acnt = 3'h1;
      run = 1'b1;
      cyc(12100);
      chk("minutes", 8'h02, mins);
      for (int m = 0; m < 3; m++) begin
         rmode = 2'(m == 2 ? 0 : m + 1);
         rreq = 1'b1;
         cyc(1);
         rreq = 1'b0;
         cyc(5);
         chk("minutes cleared", 8'h00, mins);
         chk("relay rotated", exp_rel(2'((m + 1) % 3), 1, 4'hf), relay);
      end
      stop();
      // Stage change with ramp times set: the command climbs to the new regulator output
      {rup, rdn, regout} = {16'h0001, 16'h0001, 16'h1388};
      drive(1'b1);
      run = 1'b1;
      wait_cnt(3'h1);
      regout = 16'h13ec;
      cyc(10);
      chk("main ramping", 16'h0001, 16'(frq > 16'h1388 && frq < 16'h13ec));
      cyc(300);
      chk("main ramped", 16'h13ec, frq);
      {rup, rdn} = 32'h0;
      stop();
      // Sleep on low frequency after the delay, wake on low feedback
      {sdel, sfreq, ofreq} = {16'h0003, 16'h03e8, 16'h01f4};
      {wake, level, refv} = {12'h400, 12'h800, 12'h800};
      run = 1'b1;
      cyc(12);
      chk("sleep early", 8'h00, slp);
      for (int i = 0; i < 200 && slp !== 1'b1; i++) cyc(1);
      chk("sleep", 8'h01, slp);
      chk("main run asleep", 8'h00, mrun);
      level = 12'h200;
      cyc(3);
      chk("woken", 8'h00, slp);
      // Bypass accepted only from sources 2, 3 and 4
      {run, byp} = 2'h1;
      for (int s = 0; s < 8; s++) begin
         src = 3'(s);
         cyc(1);
         chk("forced vf", 8'(s >= 2 && s <= 4), vf);
         chk("regulator enabled", 8'(!(s >= 2 && s <= 4)), regen);
      end
      // Bypass level control: one attached motor gives two feedback regions
      {src, run, level, sdel} = {3'h2, 1'b1, 12'h400, 16'h0000};
      cyc(20);
      chk("bypass count low", 16'h0000, cnt);
      chk("bypass freq low", bp_exp(fb, 2), frq);
      level = 12'hc00;
      cyc(20);
      chk("bypass count high", 16'h0001, cnt);
      chk("bypass freq high", bp_exp(fb, 2), frq);
      {run, byp} = 2'h0;
      summarize();
   end
   // Watchdog well past the expected run of about 14000 cycles
   initial begin
      #600000;
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
